// File: sfpi_pkg.sv
// Package for the serial flash pin interface: constants and carriers.
// Assumes a single system clock at 25 MHz sampling the serial pins.
package sfpi_pkg;
  localparam int unsigned SFPI_CLK_HZ = 25000000;
  localparam int unsigned SFPI_PAGES = 8192;
  localparam int unsigned SFPI_PAGE_BIN = 512;
  localparam int unsigned SFPI_PAGE_STD = 528;
  localparam int unsigned SFPI_SEC_BYTES = 128;
  localparam int unsigned SFPI_SEC_USER = 64;
  localparam int unsigned SFPI_BUF_AW = 10;
  localparam int unsigned SFPI_SECTORS = 16;
  localparam int unsigned SFPI_FIFO_DEPTH = 4;
  // Self-timed job length in microseconds and its cycle count
  localparam int unsigned SFPI_PROG_US = 100;
  localparam int unsigned SFPI_PROG_CYC = SFPI_PROG_US * (SFPI_CLK_HZ / 1000000);
  localparam logic SFPI_PAGE_BIN_RST = 1'b0;
  localparam logic [7:0] SFPI_OP_BUF1_WR = 8'h84;
  localparam logic [7:0] SFPI_OP_BUF2_WR = 8'h87;
  localparam logic [7:0] SFPI_OP_BUF1_RD = 8'hD4;
  localparam logic [7:0] SFPI_OP_BUF2_RD = 8'hD6;
  localparam logic [7:0] SFPI_OP_PROG1 = 8'h83;
  localparam logic [7:0] SFPI_OP_PROG2 = 8'h86;
  localparam logic [7:0] SFPI_OP_ERASE = 8'h81;
  localparam logic [7:0] SFPI_OP_SECP_WR = 8'h3F;
  localparam logic [7:0] SFPI_OP_SEC_RD = 8'h77;
  localparam logic [7:0] SFPI_OP_STAT_RD = 8'hD7;
  localparam logic [7:0] SFPI_OP_BIN_CFG = 8'hA6;
  localparam logic [7:0] SFPI_ID_VALUE = 8'h5A; // Arbitrary value

  typedef struct packed {
    logic sel_n;
    logic sck;
    logic sdi;
    logic wp_n;
  } sfpi_pins_s;

  typedef struct packed {
    logic [7:0] data;
  } sfpi_byte_s;
endpackage : sfpi_pkg

// File: sfpi_fifo.sv
// Small synchronous FIFO carrying received bytes to the buffer and protection-flag writers.
// Assumes one clock domain; both sides use valid and ready.
module sfpi_fifo
  import sfpi_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic flush_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_r != '0);
  assign rd_data_out = mem_r[rp_r];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfpi_fifo

// File: sfpi_core.sv
// Device-side serial pin engine of a paged flash with two page buffers.
// Assumes pins arrive asynchronously; clk_in oversamples the serial clock.
module sfpi_core
  import sfpi_pkg::*;
#(
  parameter int unsigned PROG_CYC = SFPI_PROG_CYC,
  parameter int unsigned FIFO_DEPTH = SFPI_FIFO_DEPTH,
  parameter int unsigned SECTORS = SFPI_SECTORS,
  parameter logic PAGE_BIN_PRESET = SFPI_PAGE_BIN_RST
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sel_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic wp_n_in,
  input wire logic [SECTORS-1:0] sw_prot_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic rdy_out,
  output logic rdy_oe_out,
  output logic standby_out,
  output logic page_bin_out
);
  typedef enum logic [4:0] {
    SFPI_IDLE = 5'h01,
    SFPI_CMD = 5'h02,
    SFPI_ADDR = 5'h04,
    SFPI_DATA = 5'h08,
    SFPI_IGNORE = 5'h10
  } sfpi_state_e;

  localparam int unsigned SA = $clog2(SECTORS);
  localparam int unsigned BW = $clog2(SFPI_PAGE_STD);

  // Two-flop synchronisers, then edge detection on the second stage
  sfpi_pins_s s1_r;
  sfpi_pins_s s2_r;
  sfpi_pins_s s3_r;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_r <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0, wp_n: 1'b1};
      s2_r <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0, wp_n: 1'b1};
      s3_r <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0, wp_n: 1'b1};
    end else begin
      s1_r <= '{sel_n: sel_n_in, sck: sck_in, sdi: sdi_in, wp_n: wp_n_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic selected;
  assign selected = !s2_r.sel_n;
  assign sel_fall = s3_r.sel_n && !s2_r.sel_n;
  assign sel_rise = !s3_r.sel_n && s2_r.sel_n;
  // Clock edges count only while selected; modes 0 and 3 both fit this
  assign sck_rise = selected && !s3_r.sck && s2_r.sck;
  assign sck_fall = selected && s3_r.sck && !s2_r.sck;

  function automatic logic is_modify(input logic [7:0] op);
    return (op == SFPI_OP_PROG1) || (op == SFPI_OP_PROG2) ||
           (op == SFPI_OP_ERASE);
  endfunction : is_modify

  function automatic logic is_read(input logic [7:0] op);
    return (op == SFPI_OP_BUF1_RD) || (op == SFPI_OP_BUF2_RD) ||
           (op == SFPI_OP_SEC_RD) || (op == SFPI_OP_STAT_RD);
  endfunction : is_read

  sfpi_state_e state_r;
  logic [2:0] bit_r;
  logic [7:0] shin_r;
  logic [7:0] op_r;
  logic [1:0] abyte_r;
  logic [23:0] addr_r;
  logic byte_done;
  assign byte_done = sck_rise && (bit_r == 3'h7);

  // Bit counter restarts on every new select fall
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_r <= '0;
      shin_r <= '0;
    end else if (sel_fall) begin
      bit_r <= '0;
    end else if (sck_rise) begin
      shin_r <= {shin_r[6:0], s2_r.sdi};
      bit_r <= bit_r + 3'h1;
    end
  end

  logic [7:0] rx_byte;
  assign rx_byte = {shin_r[6:0], s2_r.sdi};

  // Self-timed job engine
  logic busy_r;
  logic [31:0] busy_cnt_r;
  logic [$clog2(SFPI_PAGES)-1:0] job_page_r;
  logic job_buf_r;
  logic job_erase_r;
  logic job_start;
  logic [SA-1:0] job_sector;
  logic prot_sect_r [SECTORS];
  logic [SECTORS-1:0] prot_vec;
  logic blocked;
  logic frozen_r;
  logic page_bin_r;

  assign job_sector = page_bin_r ? addr_r[21:22-SA] : addr_r[22:23-SA];
  genvar g;
  generate
    for (g = 0; g < SECTORS; g++) begin : g_prot
      assign prot_vec[g] = prot_sect_r[g];
    end
  endgenerate
  // Hardware gate uses only the register flags; software gate separate
  assign blocked = (!s2_r.wp_n && prot_vec[job_sector]) ||
                   sw_prot_in[job_sector];
  assign job_start = sel_rise && (state_r == SFPI_DATA || state_r == SFPI_ADDR)
                     && (abyte_r == 2'h3) && is_modify(op_r) && !blocked
                     && !busy_r;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
      job_buf_r <= 1'b0;
      job_erase_r <= 1'b0;
      job_page_r <= '0;
    end else if (job_start) begin
      busy_r <= 1'b1;
      busy_cnt_r <= 32'(PROG_CYC);
      job_buf_r <= (op_r == SFPI_OP_PROG2);
      job_erase_r <= (op_r == SFPI_OP_ERASE);
      // Page number sits above the byte field, whose width follows page size
      job_page_r <= page_bin_r ? addr_r[21:9] : addr_r[22:10];
    end else if (busy_r) begin
      if (busy_cnt_r <= 32'h1) begin
        busy_r <= 1'b0;
      end
      busy_cnt_r <= busy_cnt_r - 32'h1;
    end
  end

  // Frozen once write-protect is seen low; reset clears
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frozen_r <= 1'b0;
    end else if (!s2_r.wp_n) begin
      frozen_r <= 1'b1;
    end
  end

  // Page size resets to 0, then is set by the preset after reset release or by SFPI_OP_BIN_CFG
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_bin_r <= 1'b0;
    end else if (sel_rise && op_r == SFPI_OP_BIN_CFG && state_r == SFPI_DATA) begin
      page_bin_r <= 1'b1;
    end else if (PAGE_BIN_PRESET) begin
      page_bin_r <= 1'b1;
    end
  end

  // Operation state machine
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= SFPI_IDLE;
      op_r <= '0;
      abyte_r <= '0;
      addr_r <= '0;
    end else if (sel_rise || !selected) begin
      state_r <= SFPI_IDLE;
    end else if (sel_fall) begin
      state_r <= SFPI_CMD;
      abyte_r <= '0;
    end else if (byte_done) begin
      unique case (state_r)
        SFPI_CMD: begin
          op_r <= rx_byte;
          state_r <= (rx_byte == SFPI_OP_STAT_RD) ? SFPI_DATA : SFPI_ADDR;
          abyte_r <= (rx_byte == SFPI_OP_STAT_RD) ? 2'h3 : 2'h0;
        end
        SFPI_ADDR: begin
          addr_r <= {addr_r[15:0], rx_byte};
          abyte_r <= abyte_r + 2'h1;
          if (abyte_r == 2'h2) begin
            state_r <= SFPI_DATA;
          end
        end
        SFPI_DATA, SFPI_IGNORE, SFPI_IDLE: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Two page buffers, security register and protection flags
  logic [7:0] buf_r [2][SFPI_PAGE_STD];
  logic [7:0] sec_r [SFPI_SEC_BYTES];
  logic [7:0] array_r [SFPI_PAGES];
  logic [BW-1:0] bidx_r;
  logic [BW-1:0] page_lim;
  assign page_lim = page_bin_r ? BW'(SFPI_PAGE_BIN - 1) : BW'(SFPI_PAGE_STD - 1);

  // Received data bytes pass through the FIFO on their way to a buffer or the protection flags
  logic wr_buf_op;
  logic fifo_in_valid;
  logic fifo_in_ready;
  sfpi_byte_s fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;
  assign wr_buf_op = (op_r == SFPI_OP_BUF1_WR) || (op_r == SFPI_OP_BUF2_WR) ||
                     (op_r == SFPI_OP_SECP_WR);
  assign fifo_in_valid = byte_done && state_r == SFPI_DATA && wr_buf_op;
  // The busy buffer stalls draining; the other buffer stays writable
  assign fifo_out_ready = !(busy_r && (job_buf_r == (op_r == SFPI_OP_BUF2_WR)));

  sfpi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .flush_in(sel_fall),
    .wr_data_in(rx_byte),
    .wr_valid_in(fifo_in_valid),
    .wr_ready_out(fifo_in_ready),
    .rd_data_out(fifo_out.data),
    .rd_valid_out(fifo_out_valid),
    .rd_ready_in(fifo_out_ready)
  );

  logic drop_r;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drop_r <= 1'b0;
    end else if (sel_fall) begin
      drop_r <= 1'b0;
    end else if (fifo_in_valid && !fifo_in_ready) begin
      drop_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bidx_r <= '0;
    end else if (byte_done && state_r == SFPI_ADDR && abyte_r == 2'h2) begin
      bidx_r <= BW'({addr_r[1:0], rx_byte}) & (page_bin_r ? BW'(9'h1FF) : '1);
    end else if ((fifo_out_valid && fifo_out_ready) ||
                 (byte_done && state_r == SFPI_DATA && is_read(op_r))) begin
      bidx_r <= (bidx_r == page_lim) ? '0 : bidx_r + 1'b1;
    end
  end

  // Flags clear at reset so an unwritten sector never gates as unknown
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < SECTORS; i++) begin
        prot_sect_r[i] <= 1'b0;
      end
    end else if (fifo_out_valid && fifo_out_ready &&
                 op_r == SFPI_OP_SECP_WR && !frozen_r) begin
      prot_sect_r[bidx_r[SA-1:0]] <= fifo_out.data[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (fifo_out_valid && fifo_out_ready && op_r != SFPI_OP_SECP_WR) begin
      buf_r[op_r == SFPI_OP_BUF2_WR][bidx_r] <= fifo_out.data;
    end
    if (busy_r && busy_cnt_r == 32'h1) begin
      array_r[job_page_r] <= job_erase_r ? 8'hFF : buf_r[job_buf_r][0];
    end
  end

  // Output shifter loads on the falling clock edge, MSB first
  logic [7:0] tx_r;
  logic [7:0] tx_src;
  always_comb begin
    tx_src = 8'h00;
    if (op_r == SFPI_OP_STAT_RD) begin
      tx_src = {!busy_r, 4'h0, frozen_r, drop_r, page_bin_r};
    end else if (op_r == SFPI_OP_SEC_RD) begin
      tx_src = (bidx_r < BW'(SFPI_SEC_USER)) ? sec_r[bidx_r[6:0]]
               : (SFPI_ID_VALUE ^ 8'(bidx_r));
    end else if (op_r == SFPI_OP_BUF1_RD || op_r == SFPI_OP_BUF2_RD) begin
      tx_src = buf_r[op_r == SFPI_OP_BUF2_RD][bidx_r];
    end
  end

  // User security bytes read as erased; no opcode here writes the user half
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < SFPI_SEC_BYTES; i++) begin
        sec_r[i] <= 8'hFF;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_r <= '0;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else if (!selected) begin
      sdo_oe_out <= 1'b0;
    end else if (sck_fall && state_r == SFPI_DATA && is_read(op_r)) begin
      sdo_oe_out <= 1'b1;
      if (bit_r == 3'h0) begin
        sdo_out <= tx_src[7];
        tx_r <= {tx_src[6:0], 1'b0};
      end else begin
        sdo_out <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Ready/busy is open drain: enable pulls the pin low
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdy_out <= 1'b0;
      rdy_oe_out <= 1'b0;
      standby_out <= 1'b1;
    end else begin
      rdy_out <= 1'b0;
      // Drops with the last count so the pin stays low exactly PROG_CYC
      rdy_oe_out <= job_start || (busy_r && busy_cnt_r > 32'h1);
      standby_out <= !selected && !busy_r && !job_start;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_bin_out <= 1'b0;
    end else begin
      page_bin_out <= page_bin_r;
    end
  end
endmodule : sfpi_core

// File: sfpi_core_checker.sv
// Timing checks on the pins of the serial flash pin engine.
// Assumes the bench shortens the self-timed job through PROG_CYC.
module sfpi_core_checker
  import sfpi_pkg::*;
#(
  parameter int unsigned PROG_CYC = 20,
  parameter int unsigned SECTORS = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sel_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic wp_n_in,
  input wire logic [SECTORS-1:0] sw_prot_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic rdy_out,
  input wire logic rdy_oe_out,
  input wire logic standby_out,
  input wire logic page_bin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic [15:0] busy_r;
  // Counts busy cycles so the job length can be pinned exactly
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_r <= 16'h0000;
    end else begin
      busy_r <= rdy_oe_out ? busy_r + 16'h0001 : 16'h0000;
    end
  end
  chk_oe_desel: assert property (sel_n_in [*5] |-> !sdo_oe_out)
    else $error("sdo driven while deselected");
  chk_oe_src: assert property ($rose(sdo_oe_out) |-> !sel_n_in)
    else $error("sdo enabled without select");
  chk_sdo_edge: assert property ($changed(sdo_out) && $past(sdo_oe_out)
    && sdo_oe_out |-> !$past(sck_in, 3))
    else $error("sdo moved without a serial clock fall");
  chk_busy_src: assert property ($rose(rdy_oe_out) |-> sel_n_in)
    else $error("busy started inside a frame");
  chk_busy_len: assert property ($fell(rdy_oe_out) |-> busy_r == 16'(PROG_CYC))
    else $error("busy length wrong");
  chk_busy_cap: assert property (rdy_oe_out |-> {16'h0000, busy_r} < PROG_CYC)
    else $error("busy too long");
  chk_busy_quiet: assert property (rdy_oe_out |-> !standby_out && !rdy_out)
    else $error("standby or ready level wrong while busy");
  chk_stby_idle: assert property ((sel_n_in && !rdy_oe_out) [*5] |-> standby_out)
    else $error("no standby when idle");
  chk_sel_active: assert property (!sel_n_in [*4] |-> !standby_out)
    else $error("standby while selected");
  chk_rst_idle: assert property ($rose(rstn_in) |-> standby_out
    && !rdy_oe_out && !sdo_oe_out)
    else $error("not idle after reset");
  cover property ($fell(rdy_oe_out));
  cover property ($rose(sdo_oe_out));
  cover property (sel_n_in && sck_in ##1 sel_n_in && !sck_in);
endmodule : sfpi_core_checker

bind sfpi_core sfpi_core_checker #(.PROG_CYC(PROG_CYC), .SECTORS(SECTORS))
  chk_inst (.clk_in(clk_in), .rstn_in(rstn_in), .sel_n_in(sel_n_in),
  .sck_in(sck_in), .sdi_in(sdi_in), .wp_n_in(wp_n_in),
  .sw_prot_in(sw_prot_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
  .rdy_out(rdy_out), .rdy_oe_out(rdy_oe_out), .standby_out(standby_out),
  .page_bin_out(page_bin_out));

// File: sfpi_host.sv
// Host model: drives select, serial clock and data in modes 0 and 3.
// Assumes the bench clock; pins move only at its falling edge.
module sfpi_host (
  input wire logic clk_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic sel_n_out,
  output logic sck_out,
  output logic sdi_out,
  output logic [7:0] rx_out,
  output logic rx_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_r = 1'b0;
  logic sdo_w;
  // A released line shows the inverse of its last level, never a copy
  always @(posedge clk_in) begin
    if (sdo_oe_in) begin
      last_r <= sdo_in;
    end
  end
  assign sdo_w = sdo_oe_in ? sdo_in : ~last_r;
  initial begin
    sel_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
    rx_out = 8'h00;
    rx_valid_out = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask : half
  task automatic open_frame(input logic m3);
    sck_out = m3;
    half();
    sel_n_out = 1'b0;
    half();
  endtask : open_frame
  task automatic close_frame(input logic m3);
    sck_out = m3;
    half();
    sel_n_out = 1'b1;
    half();
  endtask : close_frame
  task automatic bit_cyc(input logic b, output logic s);
    sck_out = 1'b0;
    sdi_out = b;
    half();
    sck_out = 1'b1;
    half();
    s = sdo_w;
  endtask : bit_cyc
  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], s);
    end
  endtask : put_byte
  task automatic get_byte();
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b0, v[i]);
    end
    rx_out = v;
    rx_valid_out = 1'b1;
    @(negedge clk_in);
    rx_valid_out = 1'b0;
  endtask : get_byte
  task automatic noise(input int n);
    repeat (n) begin
      sck_out = 1'($urandom);
      sdi_out = 1'($urandom);
      half();
    end
  endtask : noise
endmodule : sfpi_host

// File: sfpi_core_tb.sv
// Self-checking bench for sfpi_core driven by the host model.
// Assumes a 25 MHz clock and a self-timed job cut to 20 cycles.
module sfpi_core_tb;
  import sfpi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PCYC = 20;
  logic clk_in = 1'b0;
  logic rstn_in, wp_n_in, sel_n, sck, sdi, sdo, sdo_oe, rdy, rdy_oe;
  logic standby, page_bin, rx_valid;
  logic [7:0] rx;
  logic [7:0] wr_val;
  logic [15:0] sw_prot = 16'h0000;
  logic [7:0] exp_q[$];
  int busy_q[$];
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int busy_n = 0;
  always #20 clk_in = ~clk_in;
  sfpi_core #(.PROG_CYC(PCYC)) sfpi_core_inst (.clk_in(clk_in),
    .rstn_in(rstn_in), .sel_n_in(sel_n), .sck_in(sck), .sdi_in(sdi),
    .wp_n_in(wp_n_in), .sw_prot_in(sw_prot), .sdo_out(sdo),
    .sdo_oe_out(sdo_oe), .rdy_out(rdy), .rdy_oe_out(rdy_oe),
    .standby_out(standby), .page_bin_out(page_bin));
  sfpi_host sfpi_host_inst (.clk_in(clk_in), .sdo_in(sdo),
    .sdo_oe_in(sdo_oe), .sel_n_out(sel_n), .sck_out(sck), .sdi_out(sdi),
    .rx_out(rx), .rx_valid_out(rx_valid));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check({24'h000000, got}, {24'h000000, exp});
  endtask : cmp_byte
  task automatic cmp_len(input int got, input int exp);
    check(got, exp);
  endtask : cmp_len
  task automatic cmp_flag(input logic got, input logic exp);
    check({31'h00000000, got}, {31'h00000000, exp});
  endtask : cmp_flag
  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic status(input logic m3, input logic [7:0] exp);
    exp_q.push_back(exp);
    sfpi_host_inst.open_frame(m3);
    sfpi_host_inst.put_byte(SFPI_OP_STAT_RD);
    sfpi_host_inst.get_byte();
    sfpi_host_inst.close_frame(m3);
  endtask : status
  task automatic rd_cmd(input logic [7:0] op, input logic [23:0] a,
    input logic [7:0] exp);
    exp_q.push_back(exp);
    sfpi_host_inst.open_frame(1'b0);
    sfpi_host_inst.put_byte(op);
    sfpi_host_inst.put_byte(a[23:16]);
    sfpi_host_inst.put_byte(a[15:8]);
    sfpi_host_inst.put_byte(a[7:0]);
    sfpi_host_inst.get_byte();
    sfpi_host_inst.close_frame(1'b0);
  endtask : rd_cmd
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
    input logic [7:0] d, input logic wd, input int busy, input logic cut);
    if (busy != 0 && !cut) busy_q.push_back(busy);
    sfpi_host_inst.open_frame(1'b0);
    sfpi_host_inst.put_byte(op);
    sfpi_host_inst.put_byte(a[23:16]);
    sfpi_host_inst.put_byte(a[15:8]);
    sfpi_host_inst.put_byte(a[7:0]);
    if (wd) sfpi_host_inst.put_byte(d);
    sfpi_host_inst.close_frame(1'b0);
    repeat (2) @(negedge clk_in);
    cmp_flag(rdy_oe, busy != 0);
    cmp_flag(standby, busy == 0);
    rstn_in = !cut;
    @(negedge clk_in);
    if (cut) cmp_flag(rdy_oe | ~standby, 1'b0);
    rstn_in = 1'b1;
    repeat (40) @(negedge clk_in);
  endtask : cmd
  // Results are matched in arrival order against the notes of the driver
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      busy_n = 0;
    end else begin
      if (rx_valid) cmp_byte(rx, exp_q.pop_front());
      if (rdy_oe) begin
        busy_n++;
      end else if (busy_n != 0) begin
        cmp_len(busy_n, busy_q.size() != 0 ? busy_q.pop_front() : 0);
        busy_n = 0;
      end
    end
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'hC181));
    rstn_in = 1'b0;
    wp_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    cmp_flag(standby, 1'b1);
    cmp_flag(page_bin, SFPI_PAGE_BIN_RST);
    rstn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    status(1'b0, 8'h80);
    status(1'b1, 8'h80);
    sfpi_host_inst.noise(40);
    status(1'b0, 8'h80);
    cmd(SFPI_OP_PROG1, 24'h000000, 8'h00, 1'b0, PCYC, 1'b0);
    // Software flag alone blocks sector 2 with write-protect released
    sw_prot = 16'h0004;
    cmd(SFPI_OP_PROG1, 24'h100000, 8'h00, 1'b0, 0, 1'b0);
    sw_prot = 16'h0000;
    wr_val = 8'($urandom);
    cmd(SFPI_OP_BUF1_WR, 24'h000005, wr_val, 1'b1, 0, 1'b0);
    rd_cmd(SFPI_OP_BUF1_RD, 24'h000005, wr_val);
    rd_cmd(SFPI_OP_SEC_RD, 24'h000000, 8'hFF);
    cmd(SFPI_OP_SECP_WR, 24'h000000, 8'h01, 1'b1, 0, 1'b0);
    wp_n_in = 1'b0;
    status(1'b0, 8'h84);
    cmd(SFPI_OP_PROG1, 24'h000000, 8'h00, 1'b0, 0, 1'b0);
    cmd(SFPI_OP_ERASE, 24'h000000, 8'h00, 1'b0, 0, 1'b0);
    cmd(SFPI_OP_PROG2, 24'h080000, 8'h00, 1'b0, PCYC, 1'b0);
    cmd(SFPI_OP_SECP_WR, 24'h000000, 8'h00, 1'b1, 0, 1'b0);
    cmd(SFPI_OP_PROG1, 24'h000000, 8'h00, 1'b0, 0, 1'b0);
    wp_n_in = 1'b1;
    cmd(SFPI_OP_PROG2, 24'h080000, 8'h00, 1'b0, PCYC, 1'b1);
    status(1'b0, 8'h80);
    cmd(SFPI_OP_BIN_CFG, 24'h000000, 8'h00, 1'b0, 0, 1'b0);
    cmp_flag(page_bin, 1'b1);
    status(1'b1, 8'h81);
    cmp_len(exp_q.size() + busy_q.size(), 0);
    final_report();
  end
endmodule : sfpi_core_tb
